//--- rtl/mcu_core_regs_interrupts.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_core_regs_interrupts #(
  parameter logic [9:0] VEC_TRAP = 10'h3f6,
  parameter logic [9:0] VEC_WAKEUP = 10'h3f8,
  parameter logic [9:0] VEC_TIMER0 = 10'h3fa,
  parameter logic [9:0] VEC_PWM = 10'h3fc,
  parameter logic [9:0] VEC_CONV = 10'h3fe
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Instruction command from decoder
  input wire core_regs_pkg::cmd_t cmd_in,
  input wire logic instr_boundary_in,
  output logic cmd_ready_out,
  output logic busy_out,
  // Peripheral pending requests
  input wire logic wakeup_irq_in,
  input wire logic timer0_irq_in,
  input wire logic pwm_timer_irq_in,
  input wire logic conv_done_irq_in,
  input wire logic ee_ready_in,
  // Mapped register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // Indexed addressing
  input wire logic [7:0] index_offset_in,
  output logic [9:0] index_addr_out,
  output logic index_prog_space_out,
  // Stack memory port
  output core_regs_pkg::stack_port_t stack_out,
  input wire logic [7:0] stack_rdata_in,
  // Programmer visible state
  output logic [9:0] next_fetch_counter_out,
  output logic [7:0] acc_out,
  output logic [7:0] cond_flags_out,
  output logic [2:0] isr_source_out
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    core_regs_pkg::seq_state_t state;
    logic [9:0] fetch;
    logic [10:0] index;
    logic [3:0] stack_ptr;
    logic [7:0] acc;
    core_regs_pkg::flags_t flags;
    logic [9:0] target;
    logic [7:0] ret_hi;
    logic set_mask_on_pop;
    logic clr_mask_on_jump;
    logic [2:0] src;
    core_regs_pkg::stack_port_t stack;
    logic [7:0] rdata;
    logic hit;
  } core_state_t;

  core_state_t cur;
  core_state_t nxt;

  logic [core_regs_pkg::NUM_SRC-1:0] req;
  logic [9:0] vec [core_regs_pkg::NUM_SRC];
  logic take_irq;
  logic trap_cmd;
  logic [2:0] pick;
  logic [7:0] flag_byte;

  // Vector table from parameters
  assign vec[core_regs_pkg::SRC_TRAP] = VEC_TRAP;
  assign vec[core_regs_pkg::SRC_WAKEUP] = VEC_WAKEUP;
  assign vec[core_regs_pkg::SRC_TIMER0] = VEC_TIMER0;
  assign vec[core_regs_pkg::SRC_PWM] = VEC_PWM;
  assign vec[core_regs_pkg::SRC_CONV] = VEC_CONV;

  // ****************************************
  // Request arbitration
  // ****************************************
  // Maskable requests and trap command
  assign trap_cmd = cmd_in.valid && (cmd_in.op == core_regs_pkg::OP_SOFT_TRAP);
  assign req[core_regs_pkg::SRC_TRAP] = 1'b0;
  assign req[core_regs_pkg::SRC_WAKEUP] = wakeup_irq_in;
  assign req[core_regs_pkg::SRC_TIMER0] = timer0_irq_in;
  assign req[core_regs_pkg::SRC_PWM] = pwm_timer_irq_in;
  assign req[core_regs_pkg::SRC_CONV] = conv_done_irq_in;

  // Highest set request wins
  always_comb
  begin
    pick = 3'h0;
    for (int i = 0; i < core_regs_pkg::NUM_SRC; i++)
    begin
      if (req[i])
      begin
        pick = 3'(i);
      end
    end
  end

  // Entry only between instructions with mask set; trap outranks all
  assign take_irq = (cur.state == core_regs_pkg::ST_IDLE) && instr_boundary_in
    && cur.flags.mask && (|req) && !trap_cmd;

  assign cmd_ready_out = (cur.state == core_regs_pkg::ST_IDLE) && !take_irq;
  assign busy_out = (cur.state != core_regs_pkg::ST_IDLE);

  // Flag byte as software sees it
  always_comb
  begin
    flag_byte = 8'h00;
    flag_byte[core_regs_pkg::FLG_WRAP] = cur.flags.wrap;
    flag_byte[core_regs_pkg::FLG_HALF] = cur.flags.half;
    flag_byte[core_regs_pkg::FLG_ZERO] = cur.flags.zero;
    flag_byte[core_regs_pkg::FLG_NEG] = cur.flags.neg;
    flag_byte[core_regs_pkg::FLG_MASK] = cur.flags.mask;
    flag_byte[core_regs_pkg::FLG_READY] = ee_ready_in;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt = cur;
    nxt.stack.wr = 1'b0;
    nxt.stack.rd = 1'b0;
    nxt.hit = 1'b0;
    nxt.rdata = 8'h00;

    // Mapped reads; accumulator and counter have no address
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        core_regs_pkg::OFS_STACK_PTR:
        begin
          nxt.rdata = {4'h0, cur.stack_ptr};
          nxt.hit = 1'b1;
        end
        core_regs_pkg::OFS_COND_FLAGS:
        begin
          nxt.rdata = flag_byte;
          nxt.hit = 1'b1;
        end
        core_regs_pkg::OFS_INDEX_UPPER:
        begin
          nxt.rdata = {6'h00, cur.index[9:8]};
          nxt.hit = 1'b1;
        end
        core_regs_pkg::OFS_INDEX_LOWER:
        begin
          nxt.rdata = cur.index[7:0];
          nxt.hit = 1'b1;
        end
        default:
        begin
          nxt.rdata = 8'h00;
          nxt.hit = 1'b0;
        end
      endcase
    end

    // Mapped writes; only the mask bit of the flags takes a write
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        core_regs_pkg::OFS_STACK_PTR: nxt.stack_ptr = reg_wdata_in[3:0];
        core_regs_pkg::OFS_COND_FLAGS:
          nxt.flags.mask = reg_wdata_in[core_regs_pkg::FLG_MASK];
        core_regs_pkg::OFS_INDEX_UPPER: nxt.index[10:8] = reg_wdata_in[2:0];
        core_regs_pkg::OFS_INDEX_LOWER: nxt.index[7:0] = reg_wdata_in;
        default:
        begin
          nxt.index = nxt.index;
        end
      endcase
    end

    unique case (cur.state)
      core_regs_pkg::ST_IDLE:
      begin
        if (take_irq)
        begin
          // Maskable entry: push current counter, vector later
          nxt.src = pick;
          nxt.target = vec[pick];
          nxt.clr_mask_on_jump = 1'b1;
          nxt.stack = {1'b1, 1'b0, core_regs_pkg::STACK_PAGE, cur.stack_ptr,
            cur.fetch[7:0]};
          nxt.state = core_regs_pkg::ST_PUSH_LO;
        end
        else if (cmd_in.valid)
        begin
          unique case (cmd_in.op)
            core_regs_pkg::OP_CALL_SUB:
            begin
              nxt.target = cmd_in.target[9:0];
              nxt.clr_mask_on_jump = 1'b0;
              nxt.stack = {1'b1, 1'b0, core_regs_pkg::STACK_PAGE, cur.stack_ptr,
                cur.fetch[7:0]};
              nxt.state = core_regs_pkg::ST_PUSH_LO;
            end
            core_regs_pkg::OP_SOFT_TRAP:
            begin
              // Taken whatever the mask holds
              nxt.src = 3'(core_regs_pkg::SRC_TRAP);
              nxt.target = vec[core_regs_pkg::SRC_TRAP];
              nxt.clr_mask_on_jump = 1'b1;
              nxt.stack = {1'b1, 1'b0, core_regs_pkg::STACK_PAGE, cur.stack_ptr,
                cur.fetch[7:0]};
              nxt.state = core_regs_pkg::ST_PUSH_LO;
            end
            core_regs_pkg::OP_SUB_EXIT, core_regs_pkg::OP_ISR_EXIT:
            begin
              // High byte sits nearer the top of stack
              nxt.set_mask_on_pop = (cmd_in.op == core_regs_pkg::OP_ISR_EXIT);
              nxt.stack = {1'b0, 1'b1, core_regs_pkg::STACK_PAGE,
                4'(cur.stack_ptr + 4'h1), 8'h00};
              nxt.state = core_regs_pkg::ST_POP_A;
            end
            core_regs_pkg::OP_JUMP:
            begin
              nxt.fetch = cmd_in.target[9:0];
            end
            default:
            begin
              nxt.fetch = 10'(cur.fetch + {8'h00, cmd_in.step});
            end
          endcase

          // Flag and data effects of ordinary instructions
          unique case (cmd_in.op)
            core_regs_pkg::OP_SET_WRAP:
            begin
              nxt.flags.wrap = 1'b1;
              nxt.flags.half = 1'b1;
            end
            core_regs_pkg::OP_CLEAR_WRAP:
            begin
              nxt.flags.wrap = 1'b0;
              nxt.flags.half = 1'b0;
            end
            core_regs_pkg::OP_LOAD_WRAP: nxt.flags.wrap = cmd_in.wrap_val;
            core_regs_pkg::OP_FLIP_WRAP: nxt.flags.wrap = !cur.flags.wrap;
            core_regs_pkg::OP_RESULT:
            begin
              // Arithmetic, logic and rotate results
              if (cmd_in.acc_wr)
              begin
                nxt.acc = cmd_in.result;
              end
              if (cmd_in.upd[0])
              begin
                nxt.flags.wrap = cmd_in.carry;
              end
              if (cmd_in.upd[1])
              begin
                nxt.flags.half = cmd_in.half;
              end
              if (cmd_in.upd[2])
              begin
                nxt.flags.zero = (cmd_in.result == 8'h00);
              end
              if (cmd_in.upd[3])
              begin
                nxt.flags.neg = cmd_in.result[7];
              end
            end
            core_regs_pkg::OP_LOAD_INDEX: nxt.index = cmd_in.target;
            core_regs_pkg::OP_SET_MASK: nxt.flags.mask = 1'b1;
            core_regs_pkg::OP_CLEAR_MASK: nxt.flags.mask = 1'b0;
            default:
            begin
              nxt.acc = nxt.acc;
            end
          endcase
        end
      end
      core_regs_pkg::ST_PUSH_LO:
      begin
        // Second byte one slot lower
        nxt.stack = {1'b1, 1'b0, core_regs_pkg::STACK_PAGE,
          4'(cur.stack_ptr - 4'h1), 6'h00, cur.fetch[9:8]};
        nxt.state = core_regs_pkg::ST_PUSH_HI;
      end
      core_regs_pkg::ST_PUSH_HI:
      begin
        nxt.stack_ptr = 4'(cur.stack_ptr - 4'h2);
        nxt.state = core_regs_pkg::ST_JUMP;
      end
      core_regs_pkg::ST_JUMP:
      begin
        nxt.fetch = cur.target;
        if (cur.clr_mask_on_jump)
        begin
          nxt.flags.mask = 1'b0;
        end
        nxt.state = core_regs_pkg::ST_SETTLE;
      end
      core_regs_pkg::ST_POP_A:
      begin
        nxt.stack = {1'b0, 1'b1, core_regs_pkg::STACK_PAGE,
          4'(cur.stack_ptr + 4'h2), 8'h00};
        nxt.state = core_regs_pkg::ST_POP_B;
      end
      core_regs_pkg::ST_POP_B:
      begin
        nxt.ret_hi = stack_rdata_in;
        nxt.state = core_regs_pkg::ST_POP_C;
      end
      core_regs_pkg::ST_POP_C:
      begin
        nxt.fetch = {cur.ret_hi[1:0], stack_rdata_in};
        nxt.stack_ptr = 4'(cur.stack_ptr + 4'h2);
        if (cur.set_mask_on_pop)
        begin
          nxt.flags.mask = 1'b1;
        end
        nxt.state = core_regs_pkg::ST_SETTLE;
      end
      core_regs_pkg::ST_SETTLE:
      begin
        // Fourth busy cycle of entry or exit
        nxt.state = core_regs_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur <= '0;
      cur.state <= core_regs_pkg::ST_IDLE;
      cur.fetch <= core_regs_pkg::FETCH_RESET;
      cur.index <= core_regs_pkg::INDEX_RESET;
      cur.stack_ptr <= core_regs_pkg::STACK_RESET;
      cur.flags <= '0;
    end
    else
    begin
      cur <= nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Indexed effective address, space chosen by top index bit
  assign index_addr_out = 10'(cur.index[9:0] + {2'h0, index_offset_in});
  assign index_prog_space_out = cur.index[10];

  // Registered state views; ready bit of the flag byte is ee_ready_in, not registered
  assign stack_out = cur.stack;
  assign reg_rdata_out = cur.rdata;
  assign reg_hit_out = cur.hit;
  assign next_fetch_counter_out = cur.fetch;
  assign acc_out = cur.acc;
  assign cond_flags_out = flag_byte;
  assign isr_source_out = cur.src;
endmodule // mcu_core_regs_interrupts
`default_nettype wire

//--- shared/core_regs_pkg.sv
`default_nettype none
package core_regs_pkg;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_STACK_PTR = 8'hbc;
  localparam logic [7:0] OFS_COND_FLAGS = 8'hbd;
  localparam logic [7:0] OFS_INDEX_UPPER = 8'hbe;
  localparam logic [7:0] OFS_INDEX_LOWER = 8'hbf;
  localparam logic [9:0] FETCH_RESET = 10'h000;
  localparam logic [3:0] STACK_RESET = 4'hf;
  localparam logic [10:0] INDEX_RESET = 11'h000;
  localparam logic [1:0] STACK_PAGE = 2'h3;

  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int FLG_WRAP = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_NEG = 3;
  localparam int FLG_MASK = 4;
  localparam int FLG_READY = 5;

  // ****************************************
  // Request indices, highest first
  // ****************************************
  localparam int SRC_TRAP = 4;
  localparam int SRC_WAKEUP = 3;
  localparam int SRC_TIMER0 = 2;
  localparam int SRC_PWM = 1;
  localparam int SRC_CONV = 0;
  localparam int NUM_SRC = 5;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADVANCE = 4'h1,
    OP_JUMP = 4'h2,
    OP_CALL_SUB = 4'h3,
    OP_SUB_EXIT = 4'h4,
    OP_ISR_EXIT = 4'h5,
    OP_SOFT_TRAP = 4'h6,
    OP_SET_WRAP = 4'h7,
    OP_CLEAR_WRAP = 4'h8,
    OP_LOAD_WRAP = 4'h9,
    OP_FLIP_WRAP = 4'ha,
    OP_RESULT = 4'hb,
    OP_LOAD_INDEX = 4'hc,
    OP_SET_MASK = 4'hd,
    OP_CLEAR_MASK = 4'he
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH_LO = 3'h1,
    ST_PUSH_HI = 3'h2,
    ST_JUMP = 3'h3,
    ST_POP_A = 3'h4,
    ST_POP_B = 3'h5,
    ST_POP_C = 3'h6,
    ST_SETTLE = 3'h7
  } seq_state_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic [1:0] step;
    logic acc_wr;
    logic [3:0] upd;
    logic [7:0] result;
    logic carry;
    logic half;
    logic wrap_val;
    logic [10:0] target;
  } cmd_t;

  typedef struct packed {
    logic neg;
    logic zero;
    logic half;
    logic wrap;
    logic mask;
  } flags_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } stack_port_t;

endpackage
`default_nettype wire

//--- tb/mcu_core_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_core_regs_props (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire core_regs_pkg::cmd_t cmd_in,
  input wire logic instr_boundary_in,
  input wire logic cmd_ready_out,
  input wire logic busy_out,
  input wire logic wakeup_irq_in,
  input wire logic timer0_irq_in,
  input wire logic pwm_timer_irq_in,
  input wire logic conv_done_irq_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic index_prog_space_out,
  input wire core_regs_pkg::stack_port_t stack_out,
  input wire logic [9:0] next_fetch_counter_out,
  input wire logic [7:0] cond_flags_out,
  input wire logic [2:0] isr_source_out
);
  // ****************************************
  // Accepted requests
  // ****************************************
  wire take = cmd_in.valid && cmd_ready_out;
  wire calls = take && cmd_in.op == core_regs_pkg::OP_CALL_SUB;
  wire trap = take && cmd_in.op == core_regs_pkg::OP_SOFT_TRAP;
  wire isr_ret = take && cmd_in.op == core_regs_pkg::OP_ISR_EXIT;
  wire exits = isr_ret || take && cmd_in.op == core_regs_pkg::OP_SUB_EXIT;
  wire mask = cond_flags_out[core_regs_pkg::FLG_MASK];
  wire any_req = wakeup_irq_in || timer0_irq_in || pwm_timer_irq_in || conv_done_irq_in;
  wire trap_cmd = cmd_in.valid && cmd_in.op == core_regs_pkg::OP_SOFT_TRAP;
  wire entry = !busy_out && instr_boundary_in && mask && any_req && !trap_cmd;
  wire start = calls || trap || exits || entry;
  wire [2:0] best = wakeup_irq_in ? 3'h3 : timer0_irq_in ? 3'h2 : pwm_timer_irq_in ? 3'h1 : 3'h0;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_reset_state: assert property ($rose(rst_n_in) |->
    next_fetch_counter_out == core_regs_pkg::FETCH_RESET && !mask)
    else $error("counter or mask wrong after reset");
  a_call_low_first: assert property (calls |=> stack_out.wr && stack_out.addr[5:4] == 2'h3
    && stack_out.wdata == $past(next_fetch_counter_out[7:0])) else $error("first push wrong");
  a_push_high_next: assert property (calls |-> ##2 stack_out.wr
    && stack_out.addr[3:0] == $past(stack_out.addr[3:0]) - 4'h1)
    else $error("second push wrong");
  a_pop_order: assert property (exits |=> stack_out.rd ##1 stack_out.rd
    && stack_out.addr[3:0] == $past(stack_out.addr[3:0]) + 4'h1) else $error("pop order wrong");
  a_busy_span: assert property (start |=> busy_out [*4] ##1 !busy_out)
    else $error("flow sequence length wrong");
  a_entry_mask: assert property ((entry || trap) |-> ##4 !mask)
    else $error("mask not cleared on entry");
  a_isr_exit_mask: assert property (isr_ret |-> ##4 mask)
    else $error("mask not set on return");
  a_mask_gates: assert property (!mask && !busy_out && !start |=> !busy_out)
    else $error("entry while masked");
  a_flag_write: assert property (reg_wr_in && reg_addr_in == core_regs_pkg::OFS_COND_FLAGS
    && !busy_out && !cmd_in.valid |=> cond_flags_out[3:0] == $past(cond_flags_out[3:0])
    && mask == $past(reg_wdata_in[4])) else $error("flag write wrong");
  a_space_select: assert property (reg_wr_in
    && reg_addr_in == core_regs_pkg::OFS_INDEX_UPPER && !cmd_in.valid
    |=> index_prog_space_out == $past(reg_wdata_in[2])) else $error("space bit");
  a_priority_order: assert property (entry |=> isr_source_out == $past(best))
    else $error("wrong source served");
  a_trap_first: assert property (trap |=> isr_source_out == 3'h4)
    else $error("trap source wrong");
endmodule // mcu_core_regs_props
bind mcu_core_regs_interrupts mcu_core_regs_props props (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .cmd_in(cmd_in), .instr_boundary_in(instr_boundary_in),
  .cmd_ready_out(cmd_ready_out), .busy_out(busy_out), .wakeup_irq_in(wakeup_irq_in),
  .timer0_irq_in(timer0_irq_in), .pwm_timer_irq_in(pwm_timer_irq_in),
  .conv_done_irq_in(conv_done_irq_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .index_prog_space_out(index_prog_space_out),
  .stack_out(stack_out), .next_fetch_counter_out(next_fetch_counter_out),
  .cond_flags_out(cond_flags_out), .isr_source_out(isr_source_out));
`default_nettype wire

//--- tb/stack_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module stack_sram_model (
  // Clock
  input wire logic clk_in,
  // Stack port
  input wire core_regs_pkg::stack_port_t stack_in,
  output logic [7:0] rdata_out
);
  // ****************************************
  // Synchronous SRAM
  // ****************************************
  logic [7:0] mem [64];
  initial rdata_out = 8'h00;
  // Write, and read one cycle late; idle data toggles
  always @(posedge clk_in)
  begin
    if (stack_in.wr)
      mem[stack_in.addr] <= stack_in.wdata;
    rdata_out <= stack_in.rd ? mem[stack_in.addr] : ~rdata_out;
  end
endmodule // stack_sram_model
`default_nettype wire

//--- tb/mcu_core_regs_interrupts_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_core_regs_interrupts_tb;
  // ****************************************
  // Bench signals
  // ****************************************
  localparam logic [9:0] V_TRAP = 10'h3e0;
  localparam logic [9:0] V_WK = 10'h3e4;
  localparam logic [9:0] V_T0 = 10'h3e8;
  localparam logic [9:0] V_PW = 10'h3ec;
  localparam logic [9:0] V_CV = 10'h3f0;
  logic clk, rst_n, bnd, wk, t0, pw, cv, eer, rw, rr, rdy, busy, hit, ips;
  logic [7:0] ra, wd, ofs, rdat, srd, acc, flg;
  logic [9:0] iaddr, fetch;
  logic [2:0] src;
  core_regs_pkg::cmd_t cmd;
  core_regs_pkg::stack_port_t stk;
  int num_errors = 0;
  int n_tests = 0;
  mcu_core_regs_interrupts #(.VEC_TRAP(V_TRAP), .VEC_WAKEUP(V_WK), .VEC_TIMER0(V_T0),
    .VEC_PWM(V_PW), .VEC_CONV(V_CV)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .cmd_in(cmd), .instr_boundary_in(bnd), .cmd_ready_out(rdy), .busy_out(busy),
    .wakeup_irq_in(wk), .timer0_irq_in(t0), .pwm_timer_irq_in(pw), .conv_done_irq_in(cv),
    .ee_ready_in(eer), .reg_addr_in(ra), .reg_wr_in(rw), .reg_rd_in(rr), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .reg_hit_out(hit), .index_offset_in(ofs), .index_addr_out(iaddr),
    .index_prog_space_out(ips), .stack_out(stk), .stack_rdata_in(srd),
    .next_fetch_counter_out(fetch), .acc_out(acc), .cond_flags_out(flg), .isr_source_out(src));
  stack_sram_model pm (.clk_in(clk), .stack_in(stk), .rdata_out(srd));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_idle;
    repeat (20) if (busy !== 1'b0) cyc(1);
    chk(busy, 1'b0);
  endtask
  // Strobes drop for one idle cycle between accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ra = a;
    wd = d;
    rw = 1'b1;
    cyc(1);
    rw = 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
    ra = a;
    rr = 1'b1;
    cyc(1);
    chk(rdat, e);
    chk(hit, h);
    rr = 1'b0;
    cyc(1);
  endtask
  task automatic issue(input core_regs_pkg::op_t o, input logic [7:0] r, input logic [3:0] u,
    input logic [10:0] t);
    core_regs_pkg::cmd_t c;
    c = '0;
    c.valid = 1'b1;
    c.op = o;
    c.acc_wr = 1'b1;
    c.upd = u;
    c.result = r;
    c.carry = r[0];
    c.half = r[1];
    c.wrap_val = r[0];
    c.target = t;
    cmd = c;
    // Hold the command until an edge with ready high
    #1;
    for (int k = 0; k < 20 && rdy !== 1'b1; k++)
      cyc(1);
    chk(rdy, 1'b1);
    cyc(1);
    cmd.valid = 1'b0;
    cyc(1);
    wait_idle;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    chk(fetch, 10'h000);
    rdc(8'hbc, 8'h0f, 1'b1);
    rdc(8'hbd, 8'h20, 1'b1);
    rdc(8'h10, 8'h00, 1'b0);
    wr(8'hbe, 8'h07);
    wr(8'hbf, 8'hf0);
    rdc(8'hbe, 8'h03, 1'b1);
    rdc(8'hbf, 8'hf0, 1'b1);
    chk(ips, 1'b1);
    chk(iaddr, 10'h010);
    issue(core_regs_pkg::OP_LOAD_INDEX, 8'h00, 4'h0, 11'h0ff);
    chk(ips, 1'b0);
    chk(iaddr, 10'h11f);
    $display("test regs done");
  endtask
  task automatic t_flags;
    issue(core_regs_pkg::OP_RESULT, 8'h81, 4'hf, 11'h0);
    chk({acc, flg}, 16'h8129);
    issue(core_regs_pkg::OP_RESULT, 8'h00, 4'hf, 11'h0);
    chk(flg, 8'h24);
    issue(core_regs_pkg::OP_RESULT, 8'h02, 4'h2, 11'h0);
    chk(flg, 8'h26);
    issue(core_regs_pkg::OP_SET_WRAP, 8'h00, 4'h0, 11'h0);
    chk(flg, 8'h27);
    issue(core_regs_pkg::OP_CLEAR_WRAP, 8'h00, 4'h0, 11'h0);
    chk(flg, 8'h24);
    issue(core_regs_pkg::OP_FLIP_WRAP, 8'h00, 4'h0, 11'h0);
    chk(flg, 8'h25);
    issue(core_regs_pkg::OP_LOAD_WRAP, 8'h00, 4'h0, 11'h0);
    chk(flg, 8'h24);
    wr(8'hbd, 8'hff);
    chk(flg, 8'h34);
    wr(8'hbd, 8'h00);
    eer = 1'b0;
    cyc(1);
    chk(flg, 8'h04);
    eer = 1'b1;
    $display("test flags done");
  endtask
  task automatic t_call;
    issue(core_regs_pkg::OP_JUMP, 8'h00, 4'h0, 11'h123);
    issue(core_regs_pkg::OP_CALL_SUB, 8'h00, 4'h0, 11'h200);
    chk({pm.mem[6'h3f], pm.mem[6'h3e]}, 16'h2301);
    chk(fetch, 10'h200);
    rdc(8'hbc, 8'h0d, 1'b1);
    issue(core_regs_pkg::OP_SUB_EXIT, 8'h00, 4'h0, 11'h0);
    chk(fetch, 10'h123);
    rdc(8'hbc, 8'h0f, 1'b1);
    $display("test call done");
  endtask
  task automatic t_irq;
    {wk, t0, pw, cv} = 4'hf;
    cyc(4);
    chk(busy, 1'b0);
    wr(8'hbd, 8'h10);
    cyc(1);
    wait_idle;
    chk({src, fetch}, {3'h3, V_WK});
    chk(flg[4], 1'b0);
    wk = 1'b0;
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    chk({flg[4], fetch}, {1'b1, 10'h123});
    cyc(1);
    wait_idle;
    chk({src, fetch}, {3'h2, V_T0});
    t0 = 1'b0;
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    cyc(1);
    wait_idle;
    chk({src, fetch}, {3'h1, V_PW});
    pw = 1'b0;
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    cyc(1);
    wait_idle;
    chk({src, fetch}, {3'h0, V_CV});
    cv = 1'b0;
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    cyc(3);
    chk({busy, flg[4]}, 2'b01);
    $display("test irq done");
  endtask
  task automatic t_trap;
    wk = 1'b1;
    issue(core_regs_pkg::OP_SOFT_TRAP, 8'h00, 4'h0, 11'h0);
    chk({src, fetch, flg[4]}, {3'h4, V_TRAP, 1'b0});
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    cyc(1);
    wait_idle;
    chk({src, fetch}, {3'h3, V_WK});
    wk = 1'b0;
    issue(core_regs_pkg::OP_ISR_EXIT, 8'h00, 4'h0, 11'h0);
    wr(8'hbd, 8'h00);
    issue(core_regs_pkg::OP_SOFT_TRAP, 8'h00, 4'h0, 11'h0);
    chk({src, fetch}, {3'h4, V_TRAP});
    issue(core_regs_pkg::OP_SUB_EXIT, 8'h00, 4'h0, 11'h0);
    chk({flg[4], fetch}, {1'b0, 10'h123});
    $display("test trap done");
  endtask
  // Watchdog
  initial
  begin
    #(25 * 5000);
    num_errors++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    cmd = '0;
    {bnd, wk, t0, pw, cv, eer, rw, rr} = 8'h84;
    {ra, wd, ofs} = {8'h00, 8'h00, 8'h20};
    cyc(16);
    rst_n = 1'b1;
    t_regs;
    t_flags;
    t_call;
    t_irq;
    t_trap;
    end_of_test;
  end
endmodule // mcu_core_regs_interrupts_tb
`default_nettype wire
